// [rtl/bc_exec_defines.svh]
// constants for the push, wait and flip executor
`ifndef BC_EXEC_DEFINES_SVH
`define BC_EXEC_DEFINES_SVH
// op codes (both-word push and flip-go share a code; exec_flip_go_sel picks)
`define OP_PUSH_TIME_HIGH   5'h19
`define OP_PUSH_TIME_BOTH   5'h1A
`define OP_PUSH_BLOCK_STAT  5'h11
`define OP_PUSH_IMMEDIATE   5'h12
`define OP_PUSH_INDIRECT    5'h13
`define OP_WAIT_TRIGGER     5'h14
`define OP_EXEC_FLIP        5'h15
`define OP_EXEC_MESSAGE     5'h01
// register word indices, byte address is four times
`define REG_NEXT_MSG_TIMER  8'h36
`define REG_TIME_TAG_CFG    8'h39
`define REG_TIME_LOW        8'h43
`define REG_TIME_HIGH       8'h44
`define REG_QUEUE_PTR       8'h38
`define REG_IRQ_STATUS      8'h50
`define REG_IRQ_MASK        8'h51
`define REG_CTRL            8'h52
// fields
`define WIDE_TIME_BIT       3
`define FLIP_MASK           16'h0010
`define QUEUE_BASE_RESET    16'h00C0
`define QUEUE_SLOT_MASK     16'h003F
`define MSG_TIMER_WORD      16'h0003
`define IRQ_TRAP_BIT        0
`define IRQ_ROLLOVER_BIT    1
`define CTRL_ROLL_EN_BIT    13
`define CTRL_TRAP_EN_BIT    0
`endif

// [rtl/bc_exec_pkg.sv]
// types for the push, wait and flip executor
package bc_exec_pkg;
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_PUSH,
		ST_PUSH_LOW,
		ST_RAM_READ,
		ST_RAM_WAIT,
		ST_WAIT_TRIG,
		ST_MSG_HOLD,
		ST_TIMER_READ,
		ST_MSG_RUN,
		ST_PACE,
		ST_HALTED
	} exec_state_t;
endpackage : bc_exec_pkg

// [rtl/bc_push_wait_flip_executor.sv]
// push, wait-trigger and execute-flip op code executor with wishbone registers
// What this block does
// - true condition on high push: queue the upper time tag word
// - false condition on conditional op: skip and fetch next op code
// - narrow time base: high/both push halt and raise illegal-op trap
// - both push: capture both words together, push high then low
// - block status push: queue last message's block status word
// - immediate push: queue the parameter word itself
// - indirect push: read RAM at parameter address, queue that word
// - wait trigger: stall until rising edge on trigger input
// - execute-flip always runs the message at parameter address
// - at completion, true condition writes back address with bit 4 flipped
// - execute-flip: nonzero fourth word loads timer, next fetch waits zero
// - flip-and-go: nonzero fourth word loads timer, message may finish first
// - after flip-and-go, non-message op codes run at once
// - later message waits for timer zero before its bus transaction
// - queue is 64-word circular buffer, pointer at next free slot
// - queue pointer resets to 0x00C0, host may relocate, advances each push
// - pointer wrap with rollover enable raises interrupt
`timescale 1ns/10ps
`include "bc_exec_defines.svh"
module bc_push_wait_flip_executor
	import bc_exec_pkg::*;
#(
	parameter int DW = 16,
	parameter int AW = 16
)
(
	// clock and reset
	input  wire logic          sys_clk,
	input  wire logic          rst_n,
	input  wire logic          clk_en,
	// wishbone slave
	input  wire logic          wb_cyc_i,
	input  wire logic          wb_stb_i,
	input  wire logic          wb_we_i,
	input  wire logic [9:0]    wb_adr_i,
	input  wire logic [3:0]    wb_sel_i,
	input  wire logic [31:0]   wb_dat_i,
	output logic      [31:0]   wb_dat_o,
	output logic               wb_ack_o,
	// instruction from sequencer
	input  wire logic          instr_valid,
	input  wire logic [4:0]    instr_opcode,
	input  wire logic [DW-1:0] instr_param,
	input  wire logic          cond_true,
	input  wire logic          exec_flip_go_sel,
	output logic               instr_done,
	output logic               fetch_allow,
	// time tag and message results
	input  wire logic [DW-1:0] time_low_in,
	input  wire logic [DW-1:0] time_high_in,
	input  wire logic [DW-1:0] block_status_in,
	// trigger pin
	input  wire logic          external_trigger_input,
	// ram port
	output logic               ram_req,
	output logic               ram_we,
	output logic [AW-1:0]      ram_addr,
	output logic [DW-1:0]      ram_wdata,
	input  wire logic          ram_ack,
	input  wire logic [DW-1:0] ram_rdata,
	// message engine
	output logic               msg_start,
	output logic [AW-1:0]      msg_block_addr,
	input  wire logic          msg_done,
	// interrupt
	output logic               irq
);
	typedef struct packed {
		exec_state_t      st;
		logic [2:0]       trig_sync;
		logic             trig_lvl;
		logic [DW-1:0]    op_param;
		logic             op_cond;
		logic             op_go;
		logic [DW-1:0]    push_low;
		logic [DW-1:0]    next_msg_timer;
		logic [DW-1:0]    time_tag_config;
		logic [AW-1:0]    queue_ptr;
		logic [AW-1:0]    queue_base;
		logic [1:0]       irq_status;
		logic [1:0]       irq_mask;
		logic [DW-1:0]    ctrl;
		logic             done;
		logic             ram_req;
		logic             ram_we;
		logic [AW-1:0]    ram_addr;
		logic [DW-1:0]    ram_wdata;
		logic             msg_start;
		logic             irq;
		logic [31:0]      wb_dat;
		logic             wb_ack;
		logic             fetch;
	} state_t;
	state_t s_q;
	state_t s_d;
	logic          wb_hit;
	logic          trig_rise;
	logic [7:0]    reg_idx;
	logic [DW-1:0] wr16;
	assign wb_hit    = wb_cyc_i && wb_stb_i && !s_q.wb_ack;
	assign reg_idx   = wb_adr_i[9:2];
	assign wr16      = wb_dat_i[DW-1:0];
	// rise only once stages two and three agree
	assign trig_rise = s_q.trig_sync[1] && s_q.trig_sync[2] && !s_q.trig_lvl;
	always_comb
	begin
		logic          push_en;
		logic [DW-1:0] push_val;
		logic [1:0]    ev;
		push_en  = 1'b0;
		push_val = '0;
		ev       = 2'b00;
		s_d      = s_q;
		s_d.done = 1'b0;
		s_d.msg_start = 1'b0;
		s_d.trig_sync = {s_q.trig_sync[1:0], external_trigger_input};
		if (s_q.trig_sync[1] == s_q.trig_sync[2])
			s_d.trig_lvl = s_q.trig_sync[2];
		// message timer decrements towards zero
		if (s_q.next_msg_timer != '0)
			s_d.next_msg_timer = s_q.next_msg_timer - 1'b1;
		case (s_q.st)
			ST_IDLE:
			begin
				if (instr_valid)
				begin
					s_d.op_cond  = cond_true;
					s_d.op_param = instr_param;
					s_d.op_go    = exec_flip_go_sel;
					if (instr_opcode == `OP_EXEC_FLIP || instr_opcode == `OP_EXEC_MESSAGE
						|| (instr_opcode == `OP_PUSH_TIME_BOTH && exec_flip_go_sel))
					begin
						s_d.op_go = (instr_opcode == `OP_PUSH_TIME_BOTH);
						s_d.op_cond = cond_true && (instr_opcode != `OP_EXEC_MESSAGE);
						s_d.st    = ST_MSG_HOLD;
					end
					else if ((instr_opcode == `OP_PUSH_TIME_HIGH || instr_opcode == `OP_PUSH_TIME_BOTH)
						&& !s_q.time_tag_config[`WIDE_TIME_BIT])
					begin
						ev[`IRQ_TRAP_BIT] = s_q.ctrl[`CTRL_TRAP_EN_BIT];
						s_d.st = ST_HALTED;
					end
					else if (!cond_true)
						s_d.done = 1'b1;
					else
					begin
						case (instr_opcode)
							`OP_PUSH_TIME_HIGH:
							begin
								push_en = 1'b1;
								push_val = time_high_in;
							end
							`OP_PUSH_TIME_BOTH:
							begin
								push_en = 1'b1;
								push_val = time_high_in;
								s_d.push_low = time_low_in;
							end
							`OP_PUSH_BLOCK_STAT:
							begin
								push_en = 1'b1;
								push_val = block_status_in;
							end
							`OP_PUSH_IMMEDIATE:
							begin
								push_en = 1'b1;
								push_val = instr_param;
							end
							`OP_PUSH_INDIRECT:
							begin
								s_d.ram_req  = 1'b1;
								s_d.ram_we   = 1'b0;
								s_d.ram_addr = instr_param;
								s_d.st       = ST_RAM_READ;
							end
							`OP_WAIT_TRIGGER: s_d.st = ST_WAIT_TRIG;
							default:          s_d.done = 1'b1;
						endcase
						if (push_en)
							s_d.st = (instr_opcode == `OP_PUSH_TIME_BOTH) ? ST_PUSH_LOW : ST_PUSH;
					end
				end
			end
			ST_PUSH, ST_PUSH_LOW:
			begin
				if (ram_ack)
				begin
					s_d.ram_req = 1'b0;
					s_d.queue_ptr = s_q.queue_base | ((s_q.queue_ptr + 1'b1) & `QUEUE_SLOT_MASK);
					if (s_d.queue_ptr == s_q.queue_base && s_q.ctrl[`CTRL_ROLL_EN_BIT])
						ev[`IRQ_ROLLOVER_BIT] = 1'b1;
					if (s_q.st == ST_PUSH_LOW)
					begin
						push_en  = 1'b1;
						push_val = s_q.push_low;
						s_d.st   = ST_PUSH;
					end
					else
					begin
						s_d.st   = ST_IDLE;
						s_d.done = 1'b1;
					end
				end
			end
			ST_RAM_READ:
			begin
				if (ram_ack)
				begin
					push_en  = 1'b1;
					push_val = ram_rdata;
					s_d.st   = ST_PUSH;
				end
			end
			ST_WAIT_TRIG:
			begin
				if (trig_rise)
				begin
					s_d.st   = ST_IDLE;
					s_d.done = 1'b1;
				end
			end
			ST_MSG_HOLD:
			begin
				if (s_q.next_msg_timer == '0)
				begin
					s_d.ram_req  = 1'b1;
					s_d.ram_we   = 1'b0;
					s_d.ram_addr = s_q.op_param + `MSG_TIMER_WORD;
					s_d.st       = ST_TIMER_READ;
				end
			end
			ST_TIMER_READ:
			begin
				if (ram_ack)
				begin
					s_d.ram_req = 1'b0;
					if (ram_rdata != '0)
						s_d.next_msg_timer = ram_rdata;
					s_d.msg_start = 1'b1;
					s_d.st        = ST_MSG_RUN;
				end
			end
			ST_MSG_RUN:
			begin
				if (msg_done)
				begin
					if (s_q.op_cond)
					begin
						s_d.ram_req   = 1'b1;
						s_d.ram_we    = 1'b1;
						s_d.ram_addr  = instr_param;
						s_d.ram_wdata = s_q.op_param ^ `FLIP_MASK;
						s_d.st        = ST_PACE;
					end
					else
						// false condition skips the write-back and goes straight to pace
						s_d.st = ST_PACE;
				end
			end
			ST_PACE:
			begin
				if (!s_q.ram_req || ram_ack)
				begin
					s_d.ram_req = 1'b0;
					s_d.ram_we  = 1'b0;
					if (s_q.op_go || s_q.next_msg_timer == '0)
					begin
						s_d.st   = ST_IDLE;
						s_d.done = 1'b1;
					end
				end
			end
			ST_HALTED: s_d.st = ST_HALTED;
			default:   s_d.st = ST_IDLE;
		endcase
		s_d.fetch = (s_d.st == ST_IDLE);
		if (push_en)
		begin
			s_d.ram_req   = 1'b1;
			s_d.ram_we    = 1'b1;
			s_d.ram_addr  = s_d.queue_ptr;
			s_d.ram_wdata = push_val;
		end
		// wishbone registers, one-cycle ack
		s_d.wb_ack = wb_hit;
		s_d.wb_dat = '0;
		if (wb_hit && !wb_we_i)
		begin
			case (reg_idx)
				`REG_NEXT_MSG_TIMER: s_d.wb_dat[DW-1:0] = s_q.next_msg_timer;
				`REG_TIME_TAG_CFG:   s_d.wb_dat[DW-1:0] = s_q.time_tag_config;
				`REG_TIME_LOW:       s_d.wb_dat[DW-1:0] = time_low_in;
				`REG_TIME_HIGH:      s_d.wb_dat[DW-1:0] = time_high_in;
				`REG_QUEUE_PTR:      s_d.wb_dat[AW-1:0] = s_q.queue_ptr;
				`REG_IRQ_STATUS:     s_d.wb_dat[1:0]    = s_q.irq_status;
				`REG_IRQ_MASK:       s_d.wb_dat[1:0]    = s_q.irq_mask;
				`REG_CTRL:           s_d.wb_dat[DW-1:0] = s_q.ctrl;
				default:             s_d.wb_dat = '0;
			endcase
		end
		if (wb_hit && wb_we_i && wb_sel_i[0] && wb_sel_i[1])
		begin
			case (reg_idx)
				`REG_NEXT_MSG_TIMER: s_d.next_msg_timer  = wr16;
				`REG_TIME_TAG_CFG:   s_d.time_tag_config = wr16;
				`REG_QUEUE_PTR:
				begin
					s_d.queue_ptr  = wr16;
					s_d.queue_base = wr16 & ~`QUEUE_SLOT_MASK;
				end
				`REG_IRQ_STATUS:     s_d.irq_status = s_q.irq_status & ~wr16[1:0];
				`REG_IRQ_MASK:       s_d.irq_mask   = wr16[1:0];
				`REG_CTRL:           s_d.ctrl       = wr16;
				default:             s_d.ctrl       = s_d.ctrl;
			endcase
		end
		// set wins over a clear in the same cycle
		s_d.irq_status = s_d.irq_status | ev;
		// a set mask bit hides its status bit
		s_d.irq = |(s_d.irq_status & ~s_d.irq_mask);
	end
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_q            <= '0;
			s_q.st         <= ST_IDLE;
			s_q.queue_ptr  <= `QUEUE_BASE_RESET;
			s_q.queue_base <= `QUEUE_BASE_RESET;
			s_q.fetch      <= 1'b1;
		end
		else if (clk_en)
		begin
			s_q <= s_d;
		end
	end
	assign wb_dat_o       = s_q.wb_dat;
	assign wb_ack_o       = s_q.wb_ack;
	assign instr_done     = s_q.done;
	assign fetch_allow    = s_q.fetch;
	assign ram_req        = s_q.ram_req;
	assign ram_we         = s_q.ram_we;
	assign ram_addr       = s_q.ram_addr;
	assign ram_wdata      = s_q.ram_wdata;
	assign msg_start      = s_q.msg_start;
	assign msg_block_addr = s_q.op_param;
	assign irq            = s_q.irq;
endmodule : bc_push_wait_flip_executor

// [sim/bc_exec_props.sv]
// port assertions of the executor
`timescale 1ns/10ps
`include "bc_exec_defines.svh"
module bc_exec_props
#(
	parameter int DW = 16,
	parameter int AW = 16
)
(
	// watched ports
	input wire logic          sys_clk,
	input wire logic          rst_n,
	input wire logic          wb_cyc_i,
	input wire logic          wb_stb_i,
	input wire logic          wb_we_i,
	input wire logic [9:0]    wb_adr_i,
	input wire logic [31:0]   wb_dat_o,
	input wire logic          wb_ack_o,
	input wire logic          instr_valid,
	input wire logic [4:0]    instr_opcode,
	input wire logic [DW-1:0] instr_param,
	input wire logic          cond_true,
	input wire logic          instr_done,
	input wire logic          fetch_allow,
	input wire logic          ram_req,
	input wire logic          ram_we,
	input wire logic [AW-1:0] ram_addr,
	input wire logic [DW-1:0] ram_wdata,
	input wire logic          ram_ack,
	input wire logic          msg_start,
	input wire logic [AW-1:0] msg_block_addr
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	logic          take;
	logic [DW-1:0] par_q;
	assign take = instr_valid && fetch_allow;
	// parameter of the last taken op
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			par_q <= '0;
		else if (take)
			par_q <= instr_param;
	end
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	a_wb_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("no ack");
	a_unmapped_zero: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && wb_adr_i == 10'h3FC |=> wb_dat_o == '0)
		else $error("unmapped read not zero");
	a_done_pulse: assert property (instr_done |=> !instr_done)
		else $error("done not a pulse");
	a_skip_fast: assert property (take && !cond_true && instr_opcode inside {`OP_PUSH_IMMEDIATE,
		`OP_PUSH_INDIRECT, `OP_PUSH_BLOCK_STAT, `OP_WAIT_TRIGGER} |=> instr_done)
		else $error("false condition not skipped");
	a_push_data: assert property (take && cond_true && instr_opcode == `OP_PUSH_IMMEDIATE
		|-> ##[1:3] ram_req && ram_we && ram_wdata == par_q)
		else $error("immediate not pushed");
	a_ram_held: assert property (ram_req && !ram_ack |=> ram_req && $stable(ram_addr) && $stable(ram_wdata))
		else $error("ram request dropped");
	a_msg_exec: assert property (take && instr_opcode == `OP_EXEC_FLIP
		|-> ##[1:1000] msg_start && msg_block_addr == par_q)
		else $error("message not started");
	// sync lag keeps the wait closed at least three cycles
	a_wait_hold: assert property (take && cond_true && instr_opcode == `OP_WAIT_TRIGGER |=> !instr_done [*3])
		else $error("wait released early");
	c_wait: cover property (take && instr_opcode == `OP_WAIT_TRIGGER);
	c_msg: cover property (msg_start);
	c_push: cover property (ram_req && ram_we);
endmodule : bc_exec_props
bind bc_push_wait_flip_executor bc_exec_props #(.DW(DW), .AW(AW)) props_u (.sys_clk, .rst_n, .wb_cyc_i,
	.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .instr_valid, .instr_opcode, .instr_param,
	.cond_true, .instr_done, .fetch_allow, .ram_req, .ram_we, .ram_addr, .ram_wdata, .ram_ack,
	.msg_start, .msg_block_addr);

// [sim/bc_exec_ram_model.sv]
// ram and message engine model facing the executor
`timescale 1ns/10ps
module bc_exec_ram_model
(
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	// ram port
	input  wire logic        ram_req,
	input  wire logic        ram_we,
	input  wire logic [15:0] ram_addr,
	input  wire logic [15:0] ram_wdata,
	output logic             ram_ack,
	output logic [15:0]      ram_rdata,
	// message engine
	input  wire logic        msg_start,
	output logic             msg_done
);
	logic [15:0] mem [0:255];
	logic [1:0]  run_q;
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < 256; i++)
				mem[i] <= 16'(i % 16 * 4);
			ram_ack   <= 1'b0;
			ram_rdata <= 16'h0000;
			run_q     <= 2'd0;
			msg_done  <= 1'b0;
		end
		else
		begin
			ram_ack   <= ram_req && !ram_ack;
			// data is stale outside ack, so it flips
			ram_rdata <= (ram_req && !ram_ack) ? mem[ram_addr[7:0]] : ~ram_rdata;
			if (ram_req && !ram_ack && ram_we)
				mem[ram_addr[7:0]] <= ram_wdata;
			run_q    <= msg_start ? 2'd2 : (run_q != 2'd0 ? run_q - 2'd1 : 2'd0);
			msg_done <= run_q == 2'd1;
		end
	end
endmodule : bc_exec_ram_model

// [sim/test_bc_push_wait_flip_executor.sv]
// self-checking bench of the push, wait and flip executor
`timescale 1ns/10ps
`include "bc_exec_defines.svh"
module test_bc_push_wait_flip_executor;
	import bc_exec_pkg::*;
	logic        sys_clk, rst_n, clk_en, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, instr_valid, cond_true;
	logic        exec_flip_go_sel, instr_done, fetch_allow, external_trigger_input, ram_req, ram_we;
	logic        ram_ack, msg_start, msg_done, irq;
	logic [9:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic [4:0]  instr_opcode;
	logic [15:0] instr_param, time_low_in, time_high_in, block_status_in, ram_addr, ram_wdata, ram_rdata;
	logic [15:0] msg_block_addr;
	int          fails, n_compared, dones, d0;
	bc_push_wait_flip_executor dut_u (.sys_clk, .rst_n, .clk_en, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .instr_valid, .instr_opcode, .instr_param, .cond_true,
		.exec_flip_go_sel, .instr_done, .fetch_allow, .time_low_in, .time_high_in, .block_status_in,
		.external_trigger_input, .ram_req, .ram_we, .ram_addr, .ram_wdata, .ram_ack, .ram_rdata,
		.msg_start, .msg_block_addr, .msg_done, .irq);
	bc_exec_ram_model ram_u (.sys_clk, .rst_n, .ram_req, .ram_we, .ram_addr, .ram_wdata, .ram_ack,
		.ram_rdata, .msg_start, .msg_done);
	initial
	begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk)
		if (instr_done === 1'b1)
			dones++;
	task automatic print_verdict;
		$display("compared %0d failed %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict
	task automatic give_up;
		fails++;
		print_verdict;
	endtask : give_up
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			fails++;
			$display("[ERR] %s exp %h got %h", s, e, g);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
		int n;
		@(posedge sys_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= w;
		wb_adr_i <= {a, 2'b00};
		wb_dat_i <= {16'h0000, d};
		for (n = 0; n < 50; n++)
		begin
			@(posedge sys_clk);
			if (wb_ack_o === 1'b1)
				break;
		end
		if (n == 50)
			give_up;
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : wb
	task automatic rchk(input string s, input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 16'h0000);
		chk(s, e, rd);
	endtask : rchk
	task automatic irq_is(input logic e);
		repeat (2) @(posedge sys_clk);
		chk("irq", e, irq);
	endtask : irq_is
	task automatic op(input logic [4:0] o, input logic [15:0] p, input logic c, input logic g, input int lim = 3000);
		int n;
		for (n = 0; n < 3000; n++)
		begin
			@(posedge sys_clk);
			if (fetch_allow === 1'b1)
				break;
		end
		if (n == 3000)
			give_up;
		instr_valid      <= 1'b1;
		instr_opcode     <= o;
		instr_param      <= p;
		cond_true        <= c;
		exec_flip_go_sel <= g;
		@(posedge sys_clk);
		instr_valid <= 1'b0;
		for (n = 0; n < lim; n++)
		begin
			@(posedge sys_clk);
			if (instr_done === 1'b1)
				break;
		end
		if (n == lim && lim > 100)
			give_up;
	endtask : op
	// a held-high pin must not release, a new edge must
	task automatic trig_wait;
		int d;
		d = dones;
		fork
			op(`OP_WAIT_TRIGGER, 16'h0000, 1'b1, 1'b0);
			begin
				repeat (30) @(posedge sys_clk);
				chk("early release", d, dones);
				external_trigger_input <= 1'b0;
				repeat (3) @(posedge sys_clk);
				external_trigger_input <= 1'b1;
			end
		join
		// let the counter take the last pulse first
		@(posedge sys_clk);
		chk("release", d + 1, dones);
	endtask : trig_wait
	initial
	begin
		rst_n = 1'b0;
		clk_en = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 10'h000;
		wb_sel_i = 4'h3;
		wb_dat_i = 32'h0000_0000;
		instr_valid = 1'b0;
		instr_opcode = 5'h00;
		instr_param = 16'h0000;
		cond_true = 1'b0;
		exec_flip_go_sel = 1'b0;
		external_trigger_input = 1'b0;
		time_low_in = 16'h5678;
		time_high_in = 16'h1234;
		block_status_in = 16'h9ABC;
		repeat (5) @(posedge sys_clk);
		rst_n <= 1'b1;
		rchk("queue ptr", 8'h38, 32'h0000_00C0);
		rchk("unmapped", 8'hFF, 32'h0000_0000);
		wb(1'b1, 8'h39, 16'h0008);
		wb(1'b1, 8'h52, 16'h2001);
		op(`OP_PUSH_IMMEDIATE, 16'h4321, 1'b1, 1'b0);
		chk("imm", 16'h4321, ram_u.mem[8'hC0]);
		op(`OP_PUSH_TIME_HIGH, 16'h0000, 1'b1, 1'b0);
		chk("high", 16'h1234, ram_u.mem[8'hC1]);
		op(`OP_PUSH_TIME_BOTH, 16'h0000, 1'b1, 1'b0);
		chk("both hi", 16'h1234, ram_u.mem[8'hC2]);
		chk("both lo", 16'h5678, ram_u.mem[8'hC3]);
		op(`OP_PUSH_BLOCK_STAT, 16'h0000, 1'b1, 1'b0);
		chk("status", 16'h9ABC, ram_u.mem[8'hC4]);
		op(`OP_PUSH_INDIRECT, 16'h0005, 1'b1, 1'b0);
		chk("indirect", 16'h0014, ram_u.mem[8'hC5]);
		op(`OP_PUSH_IMMEDIATE, 16'h7777, 1'b0, 1'b0);
		rchk("skip ptr", 8'h38, 32'h0000_00C6);
		wb(1'b1, 8'h38, 16'h00FF);
		op(`OP_PUSH_IMMEDIATE, 16'h00AA, 1'b1, 1'b0);
		chk("last slot", 16'h00AA, ram_u.mem[8'hFF]);
		rchk("wrap ptr", 8'h38, 32'h0000_00C0);
		irq_is(1'b1);
		wb(1'b1, 8'h51, 16'h0002);
		irq_is(1'b0);
		wb(1'b1, 8'h50, 16'h0002);
		wb(1'b1, 8'h51, 16'h0000);
		rchk("cleared", 8'h50, 32'h0000_0000);
		trig_wait;
		trig_wait;
		op(`OP_EXEC_FLIP, 16'h0020, 1'b1, 1'b0);
		chk("flip", 16'h0030, ram_u.mem[8'h20]);
		rchk("flip timer", 8'h36, 32'h0000_0000);
		op(`OP_EXEC_FLIP, 16'h0040, 1'b0, 1'b0);
		chk("no flip", 16'h0000, ram_u.mem[8'h40]);
		op(`OP_PUSH_TIME_BOTH, 16'h0028, 1'b1, 1'b1);
		chk("go flip", 16'h0038, ram_u.mem[8'h28]);
		op(`OP_PUSH_IMMEDIATE, 16'h0001, 1'b1, 1'b0);
		wb(1'b0, 8'h36, 16'h0000);
		chk("go timer", 1'b1, rd[15:0] != 16'h0000);
		op(`OP_EXEC_FLIP, 16'h0020, 1'b1, 1'b0);
		rchk("held timer", 8'h36, 32'h0000_0000);
		op(`OP_EXEC_MESSAGE, 16'h0060, 1'b1, 1'b0);
		chk("plain exec", 16'h0000, ram_u.mem[8'h60]);
		wb(1'b1, 8'h39, 16'h0000);
		d0 = dones;
		op(`OP_PUSH_TIME_HIGH, 16'h0000, 1'b1, 1'b0, 40);
		chk("halted", d0, dones);
		rchk("trap", 8'h50, 32'h0000_0001);
		irq_is(1'b1);
		chk("halt fetch", 1'b0, fetch_allow);
		print_verdict;
	end
endmodule : test_bc_push_wait_flip_executor
